// *** rafm_pkg.sv ***
// Shared constants, message codes and event codes of the redundancy arbiter and fault monitor.
package rafm_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    // Cycles of the 20 MHz clock in one millisecond of wall clock time.
    localparam int TICK_MS_CYCLES = CLK_HZ / MS_PER_S;
    // Power-down separation that lets the later chassis win, in seconds.
    localparam int PD_APART_S = 1;
    localparam logic [31:0] PD_APART_MS = 32'(PD_APART_S * MS_PER_S);
    // Clock step that counts as a clock change, in seconds.
    localparam int CLK_STEP_S = 1;
    localparam logic [31:0] CLK_STEP_MS = 32'(CLK_STEP_S * MS_PER_S);

    // ****************************************************************
    // Link words
    // ****************************************************************
    localparam int DATA_W = 32;
    localparam int SERIAL_W = 24;
    localparam int ST_PRIMARY_BIT = 31;
    localparam int ST_NRC_BIT = 30;
    localparam int ST_FAULT_BIT = 29;

    typedef enum logic [2:0] {
        MSG_NONE,
        MSG_STATUS,
        MSG_PDTIME,
        MSG_TIME,
        MSG_LASTGASP
    } rafm_msg_type;

    // ****************************************************************
    // Event log
    // ****************************************************************
    localparam int GLOB_N = 7;
    localparam int SLOT_W = 5;
    localparam logic [31:0] EVNUM_RESET = 32'h0000_0000;
    localparam logic [31:0] WALL_RESET = 32'h0000_0000;

    typedef enum logic [7:0] {
        EV_FAULT_ACTIVE,
        EV_FAULT_INACTIVE,
        EV_PARTNER_CONNECTED,
        EV_PARTNER_SCREAM,
        EV_CABLE_BREAK,
        EV_CLOCK_CHANGE,
        EV_BRIDGE_LOST,
        EV_MODULE_INSERT,
        EV_MODULE_REMOVE,
        EV_NET_ISOLATED,
        EV_NET_RESTORED
    } rafm_event_type;

endpackage : rafm_pkg

// *** rafm_link_if.sv ***
// Fiber interconnect between the redundancy module and its partner.
`timescale 1ns/1ps
interface rafm_link_if;
    import rafm_pkg::*;
    logic devLight;
    logic devValid;
    rafm_msg_type devCode;
    logic [DATA_W-1:0] devData;
    logic ptnLight;
    logic ptnValid;
    rafm_msg_type ptnCode;
    logic [DATA_W-1:0] ptnData;

    modport device_end (
        output devLight, devValid, devCode, devData,
        input ptnLight, ptnValid, ptnCode, ptnData
    );
    modport partner_end (
        input devLight, devValid, devCode, devData,
        output ptnLight, ptnValid, ptnCode, ptnData
    );
endinterface : rafm_link_if

// *** rafm_partner_end.sv ***
// Partner redundancy module end of the fiber interconnect.
`timescale 1ns/1ps
module rafm_partner_end
    import rafm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    rafm_link_if.partner_end link,
    input wire logic lightOn,
    input wire logic powerFail,
    input wire logic txValid,
    output logic txReady,
    input wire rafm_msg_type txCode,
    input wire logic [DATA_W-1:0] txData,
    output logic rxValid,
    output rafm_msg_type rxCode,
    output logic [DATA_W-1:0] rxData,
    output logic deviceLight
);

    logic gaspSent;
    logic gaspDue;
    logic txFire;
    logic outValid;
    rafm_msg_type outCode;
    logic [DATA_W-1:0] outData;

    // ****************************************************************
    // Transmit
    // ****************************************************************
    // A power failure preempts user traffic with the last-gasp message.
    assign gaspDue = powerFail && !gaspSent;
    assign txReady = !powerFail && !gaspSent && lightOn;
    assign txFire = txValid && txReady;

    // One message per cycle; after the last gasp the light goes dark.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gaspSent <= 1'b0;
            outValid <= 1'b0;
            outCode <= MSG_NONE;
            outData <= '0;
        end else begin
            outValid <= gaspDue || txFire;
            outCode <= gaspDue ? MSG_LASTGASP : (txFire ? txCode : MSG_NONE);
            outData <= gaspDue ? '0 : txData;
            if (gaspDue) begin
                gaspSent <= 1'b1;
            end
        end
    end

    assign link.ptnValid = outValid;
    assign link.ptnCode = outCode;
    assign link.ptnData = outData;
    assign link.ptnLight = lightOn && !(gaspSent && !outValid);

    // ****************************************************************
    // Receive
    // ****************************************************************
    // Incoming words are registered before the user sees them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxValid <= 1'b0;
            rxCode <= MSG_NONE;
            rxData <= '0;
            deviceLight <= 1'b0;
        end else begin
            rxValid <= link.devValid;
            rxCode <= link.devCode;
            rxData <= link.devData;
            deviceLight <= link.devLight;
        end
    end

endmodule : rafm_partner_end

// *** rafm_device_end.sv ***
// Redundancy module: power-up arbitration, fault line watch, link watch and event log.
`timescale 1ns/1ps
module rafm_device_end
    import rafm_pkg::*;
#(
    parameter int NSLOTS = 16,
    parameter logic [SLOT_W-1:0] OWN_SLOT = 5'h00,
    parameter int TICK_CYCLES = TICK_MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    rafm_link_if.device_end link,
    input wire logic faultLine_n,
    input wire logic [NSLOTS-1:0] moduleVisible,
    input wire logic [NSLOTS-1:0] netIsolated,
    input wire logic bridgeUnreachable,
    input wire logic powerFail,
    input wire logic localPrimary,
    input wire logic localNonRedundant,
    input wire logic localFaulted,
    input wire logic [31:0] localPowerDownMs,
    input wire logic [SERIAL_W-1:0] localSerial,
    input wire logic cfgTimeValid,
    input wire logic [31:0] cfgTime,
    output logic isPrimary,
    output logic switchover,
    output logic [31:0] wallClock,
    output logic logValid,
    output logic [31:0] logNumber,
    output logic [31:0] logTime,
    output logic [SLOT_W-1:0] logSlot,
    output rafm_event_type logCode
);

    localparam int EVN = GLOB_N + 4 * NSLOTS;

    typedef enum {ST_DOWN, ST_ARB, ST_PRIMARY, ST_SECONDARY, ST_GASP} rafm_state_type;

    rafm_state_type state;
    rafm_state_type next_state;
    logic [1:0] faultSync;
    logic [1:0] pfSync;
    logic [1:0] bridgeSync;
    logic [NSLOTS-1:0] visMeta, visSync, visPrev;
    logic [NSLOTS-1:0] isoMeta, isoSync, isoPrev;
    logic faultPrev, pfPrev, bridgePrev, lightPrev;
    logic [31:0] tickCnt;
    logic [DATA_W-1:0] ptnStatus;
    logic [31:0] ptnPd;
    logic gotStatus, gotPd, gaspSeen;
    logic sendStatus, sendPd, sendTime, gaspSent;
    logic txValid;
    rafm_msg_type txCode;
    logic [DATA_W-1:0] txData;
    logic [EVN-1:0] pend, raise, grant;
    rafm_event_type selCode;
    logic [SLOT_W-1:0] selSlot;
    logic anyPend;

    // ****************************************************************
    // Pin synchronisers and edges
    // ****************************************************************
    // Backplane and power pins pass two flip-flops before use.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultSync <= 2'h3;
            pfSync <= 2'h0;
            bridgeSync <= 2'h0;
            visMeta <= '0;
            visSync <= '0;
            isoMeta <= '0;
            isoSync <= '0;
        end else begin
            faultSync <= {faultSync[0], faultLine_n};
            pfSync <= {pfSync[0], powerFail};
            bridgeSync <= {bridgeSync[0], bridgeUnreachable};
            visMeta <= moduleVisible;
            visSync <= visMeta;
            isoMeta <= netIsolated;
            isoSync <= isoMeta;
        end
    end

    // Previous values give the edges that raise events.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultPrev <= 1'b1;
            pfPrev <= 1'b0;
            bridgePrev <= 1'b0;
            lightPrev <= 1'b0;
            visPrev <= '0;
            isoPrev <= '0;
        end else begin
            faultPrev <= faultSync[1];
            pfPrev <= pfSync[1];
            bridgePrev <= bridgeSync[1];
            lightPrev <= link.ptnLight;
            visPrev <= visSync;
            isoPrev <= isoSync;
        end
    end

    wire faultFall = faultPrev && !faultSync[1];
    wire faultRise = !faultPrev && faultSync[1];
    wire powerLost = pfSync[1] && !pfPrev;
    wire bridgeLost = bridgeSync[1] && !bridgePrev;
    wire linkUp = link.ptnLight && !lightPrev;
    wire linkDown = !link.ptnLight && lightPrev;
    wire rxStatus = link.ptnValid && (link.ptnCode == MSG_STATUS);
    wire rxPd = link.ptnValid && (link.ptnCode == MSG_PDTIME);
    wire rxTime = link.ptnValid && (link.ptnCode == MSG_TIME);
    wire rxGasp = link.ptnValid && (link.ptnCode == MSG_LASTGASP);

    // ****************************************************************
    // Wall clock
    // ****************************************************************
    wire tick = (tickCnt == 32'(TICK_CYCLES - 1));
    wire timeLoad = cfgTimeValid || (rxTime && state == ST_SECONDARY);
    wire [31:0] newTime = cfgTimeValid ? cfgTime : link.ptnData;
    wire [31:0] stepUp = newTime - wallClock;
    wire [31:0] stepDown = wallClock - newTime;
    wire bigStep = (newTime > wallClock) ? (stepUp > CLK_STEP_MS) : (stepDown > CLK_STEP_MS);

    // Millisecond count; a load from the primary or from configuration replaces it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt <= '0;
            wallClock <= WALL_RESET;
        end else begin
            tickCnt <= tick ? '0 : tickCnt + 32'h1;
            if (timeLoad) begin
                wallClock <= newTime;
            end else if (tick) begin
                wallClock <= wallClock + 32'h1;
            end
        end
    end

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    wire ptnPrim = ptnStatus[ST_PRIMARY_BIT];
    wire ptnNrc = ptnStatus[ST_NRC_BIT];
    wire ptnFault = ptnStatus[ST_FAULT_BIT];
    wire [31:0] pdDiff = (localPowerDownMs > ptnPd) ? localPowerDownMs - ptnPd
                                                    : ptnPd - localPowerDownMs;
    wire pdApart = pdDiff > PD_APART_MS;
    wire standbyTie = 1'b1;
    wire serialWin = localSerial < ptnStatus[SERIAL_W-1:0];
    // Each check before the serial one decides only when the two sides differ (power-down times by over PD_APART_MS), else the next one is tried.
    wire localWin = (localPrimary != ptnPrim) ? localPrimary :
                    (localFaulted != ptnFault) ? ptnFault :
                    (localNonRedundant != ptnNrc) ? ptnNrc :
                    pdApart ? (localPowerDownMs > ptnPd) :
                    standbyTie ? serialWin : 1'b0;
    wire arbReady = gotStatus && gotPd;

    // Role sequencing across link events and power loss.
    always_comb begin
        next_state = state;
        case (state)
            ST_DOWN: if (linkUp) next_state = ST_ARB;
            ST_ARB: begin
                if (linkDown) next_state = ST_DOWN;
                else if (arbReady) next_state = localWin ? ST_PRIMARY : ST_SECONDARY;
            end
            ST_PRIMARY: if (linkUp) next_state = ST_ARB;
            ST_SECONDARY: begin
                if (rxGasp) next_state = ST_PRIMARY;
                else if (linkUp) next_state = ST_ARB;
            end
            ST_GASP: next_state = ST_GASP;
            default: next_state = ST_DOWN;
        endcase
        if (powerLost) next_state = ST_GASP;
    end

    // State, partner words, their arrival flags and the flag that qualifies a link loss.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_DOWN;
            ptnStatus <= '0;
            ptnPd <= '0;
            gotStatus <= 1'b0;
            gotPd <= 1'b0;
            gaspSeen <= 1'b0;
            switchover <= 1'b0;
        end else begin
            state <= next_state;
            switchover <= (state == ST_SECONDARY) && rxGasp;
            if (rxStatus) ptnStatus <= link.ptnData;
            if (rxPd) ptnPd <= link.ptnData;
            gotStatus <= !linkUp && (gotStatus || rxStatus);
            gotPd <= !linkUp && (gotPd || rxPd);
            gaspSeen <= !linkUp && (gaspSeen || rxGasp);
        end
    end

    assign isPrimary = (state == ST_PRIMARY);

    // ****************************************************************
    // Transmit
    // ****************************************************************
    wire gaspDue = (state == ST_GASP) && !gaspSent;
    wire becomePrimary = (state == ST_ARB) && arbReady && localWin;

    // One message per cycle: last gasp first, then status, power-down time, time.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sendStatus <= 1'b0;
            sendPd <= 1'b0;
            sendTime <= 1'b0;
            gaspSent <= 1'b0;
            txValid <= 1'b0;
            txCode <= MSG_NONE;
            txData <= '0;
        end else begin
            txValid <= gaspDue || sendStatus || sendPd || sendTime;
            if (gaspDue) begin
                txCode <= MSG_LASTGASP;
                txData <= '0;
                gaspSent <= 1'b1;
            end else if (sendStatus) begin
                txCode <= MSG_STATUS;
                txData <= {isPrimary || localPrimary, localNonRedundant, localFaulted,
                           5'h00, localSerial};
            end else if (sendPd) begin
                txCode <= MSG_PDTIME;
                txData <= localPowerDownMs;
            end else begin
                txCode <= sendTime ? MSG_TIME : MSG_NONE;
                txData <= wallClock;
            end
            sendStatus <= linkUp || (sendStatus && gaspDue);
            sendPd <= linkUp || (sendPd && (gaspDue || sendStatus));
            sendTime <= becomePrimary || (sendTime && (gaspDue || sendStatus || sendPd));
        end
    end

    assign link.devValid = txValid && state != ST_DOWN;
    assign link.devCode = txCode;
    assign link.devData = txData;
    assign link.devLight = !(gaspSent && !txValid);

    // ****************************************************************
    // Event log
    // ****************************************************************
    assign raise = {isoPrev & ~isoSync,
                    isoSync & ~isoPrev,
                    visPrev & ~visSync,
                    visSync & ~visPrev,
                    bridgeLost,
                    timeLoad && bigStep,
                    linkDown && !gaspSeen && !rxGasp,
                    rxGasp,
                    linkUp,
                    faultRise,
                    faultFall};

    // Lowest pending event goes out first; its code and slot follow its index.
    always_comb begin
        grant = '0;
        anyPend = 1'b0;
        selCode = EV_FAULT_ACTIVE;
        selSlot = OWN_SLOT;
        for (int i = 0; i < EVN; i++) begin
            if (pend[i] && !anyPend) begin
                anyPend = 1'b1;
                grant[i] = 1'b1;
                if (i < GLOB_N) begin
                    selCode = rafm_event_type'(i);
                end else begin
                    selCode = rafm_event_type'(GLOB_N + (i - GLOB_N) / NSLOTS);
                    selSlot = SLOT_W'((i - GLOB_N) % NSLOTS);
                end
            end
        end
    end

    // A new event wins over the clear of the one being emitted.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= '0;
            logValid <= 1'b0;
            logNumber <= EVNUM_RESET;
            logTime <= WALL_RESET;
            logSlot <= '0;
            logCode <= EV_FAULT_ACTIVE;
        end else begin
            pend <= (pend & ~grant) | raise;
            logValid <= anyPend;
            if (anyPend) begin
                logNumber <= logNumber + 32'h1;
                logTime <= wallClock;
                logSlot <= selSlot;
                logCode <= selCode;
            end
        end
    end

endmodule : rafm_device_end

// *** rafm_asserts.sv ***
// Concurrent checks on the link and the event log of the redundancy module.
`timescale 1ns/1ps
module rafm_asserts
    import rafm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic devLight,
    input wire logic devValid,
    input wire rafm_msg_type devCode,
    input wire logic ptnLight,
    input wire logic ptnValid,
    input wire rafm_msg_type ptnCode,
    input wire logic faultLine_n,
    input wire logic powerFail,
    input wire logic isPrimary,
    input wire logic switchover,
    input wire logic logValid,
    input wire logic [31:0] logNumber,
    input wire rafm_event_type logCode
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Event numbers step by one per event and stand still in between.
    property p_num_step;
        logValid |-> logNumber == $past(logNumber) + 32'h1;
    endproperty
    a_num_step: assert property (p_num_step) else $error("log number step");
    property p_num_hold;
        !logValid |-> $stable(logNumber);
    endproperty
    a_num_hold: assert property (p_num_hold) else $error("log number moved");
    // A falling fault line is logged promptly, and never without cause.
    property p_fault_log;
        $fell(faultLine_n) |-> ##[3:8] (logValid && logCode == EV_FAULT_ACTIVE);
    endproperty
    a_fault_log: assert property (p_fault_log) else $error("fault not logged");
    property p_fault_cause;
        (logValid && logCode == EV_FAULT_ACTIVE) |-> !$past(faultLine_n, 2);
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault while idle");
    // A last gasp makes a secondary primary with a single switchover pulse.
    property p_gasp_switch;
        (ptnValid && ptnCode == MSG_LASTGASP && !isPrimary) |=>
            (switchover && isPrimary) ##1 !switchover;
    endproperty
    a_gasp_switch: assert property (p_gasp_switch) else $error("no switchover");
    property p_switch_cause;
        switchover |-> $past(ptnValid) && $past(ptnCode) == MSG_LASTGASP;
    endproperty
    a_switch_cause: assert property (p_switch_cause) else $error("stray switchover");
    property p_cable_keep;
        $fell(ptnLight) |=> $stable(isPrimary) [*3];
    endproperty
    a_cable_keep: assert property (p_cable_keep) else $error("role changed");
    // Own power loss sends a last gasp, after which the light goes out.
    property p_power_gasp;
        $rose(powerFail) |-> ##[2:10] (devValid && devCode == MSG_LASTGASP);
    endproperty
    a_power_gasp: assert property (p_power_gasp) else $error("no last gasp");
    property p_gasp_dark;
        (devValid && devCode == MSG_LASTGASP) |-> ##[1:4] !devLight;
    endproperty
    a_gasp_dark: assert property (p_gasp_dark) else $error("light stays on");
    // Main scenarios reached.
    c_switch: cover property (switchover);
    c_clock: cover property (logValid && logCode == EV_CLOCK_CHANGE);
    c_cable: cover property ($fell(ptnLight) && !isPrimary);
endmodule : rafm_asserts

// *** tb_redundancy_arbiter_fault_monitor.sv ***
// Self-checking testbench of the redundancy module facing its partner end.
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    checks++; \
    if ((s) !== (e)) begin \
        mismatches++; \
        $display("unexpected %s expected %0h seen %0h", n, e, s); \
    end \
end
module tb_redundancy_arbiter_fault_monitor;
    import rafm_pkg::*;
    localparam logic [4:0] ANY = 5'h1F;
    logic clk = 1'b0, rst_n = 1'b0, lightOn = 1'b0, ptnPowerFail = 1'b0, txValid = 1'b0;
    rafm_msg_type txCode = MSG_NONE, rxCode;
    logic [31:0] txData = 32'h0, cfgTime = 32'h0, localPowerDownMs = 32'h0000_2000;
    logic faultLine_n = 1'b1, bridgeUnreachable = 1'b0, powerFail = 1'b0, cfgTimeValid = 1'b0;
    logic [15:0] moduleVisible = 16'h0000, netIsolated = 16'h0000;
    logic localPrimary = 1'b0, localNonRedundant = 1'b0, localFaulted = 1'b0;
    logic [23:0] localSerial = 24'h0;
    logic txReady, rxValid, deviceLight, isPrimary, switchover, logValid;
    logic [31:0] rxData, wallClock, logNumber, logTime, rnd = 32'h0000_0024;
    logic [4:0] logSlot, es, sl, expSlot[$];
    rafm_event_type logCode, ec, expCode[$];
    logic modelPrimary = 1'b0, linkUp = 1'b0, gasped = 1'b0, gaspRx = 1'b0;
    int checks = 0, mismatches = 0, expNum = 0, swSeen = 0, swExp = 0;
    rafm_link_if link();
    rafm_device_end #(.TICK_CYCLES(4)) u_rafm_device_end (.clk, .rst_n, .link, .faultLine_n,
        .moduleVisible, .netIsolated, .bridgeUnreachable, .powerFail, .localPrimary,
        .localNonRedundant, .localFaulted, .localPowerDownMs, .localSerial, .cfgTimeValid,
        .cfgTime, .isPrimary, .switchover, .wallClock, .logValid, .logNumber, .logTime,
        .logSlot, .logCode);
    rafm_partner_end u_rafm_partner_end (.clk, .rst_n, .link, .lightOn,
        .powerFail(ptnPowerFail), .txValid, .txReady, .txCode, .txData, .rxValid, .rxCode,
        .rxData, .deviceLight);
    rafm_asserts u_rafm_asserts (.clk, .rst_n, .devLight(link.devLight),
        .devValid(link.devValid), .devCode(link.devCode), .ptnLight(link.ptnLight),
        .ptnValid(link.ptnValid), .ptnCode(link.ptnCode), .faultLine_n, .powerFail,
        .isPrimary, .switchover, .logValid, .logNumber, .logCode);
    // ****************************************************************
    // Clock, model and helpers
    // ****************************************************************
    // The 20 MHz clock.
    always #25 clk = ~clk;
    // Compares each log event and each power-down time word with the model.
    always @(negedge clk) begin
        if (switchover === 1'b1) swSeen++;
        if (rxValid === 1'b1 && rxCode === MSG_LASTGASP) gaspRx = 1'b1;
        if (rxValid === 1'b1 && rxCode === MSG_PDTIME) begin
            `CHK("rxPd", localPowerDownMs, rxData)
        end
        if (logValid === 1'b1) begin
            `CHK("logQueued", 1'b1, expCode.size() > 0)
            if (expCode.size() > 0) begin
                ec = expCode.pop_front();
                es = expSlot.pop_front();
                expNum++;
                `CHK("logCode", ec, logCode)
                `CHK("logNumber", 32'(expNum), logNumber)
                `CHK("logTime", 1'b1, wallClock - logTime < 32'h2)
                if (es !== ANY) `CHK("logSlot", es, logSlot)
            end
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Expected arbitration winner: primary, faults, redundancy, power-down, serial.
    function automatic logic decide(input logic [31:0] st, input logic [31:0] pd);
        if (localPrimary != st[ST_PRIMARY_BIT]) return localPrimary;
        if (localFaulted != st[ST_FAULT_BIT]) return st[ST_FAULT_BIT];
        if (localNonRedundant != st[ST_NRC_BIT]) return st[ST_NRC_BIT];
        if (localPowerDownMs > pd + PD_APART_MS) return 1'b1;
        if (pd > localPowerDownMs + PD_APART_MS) return 1'b0;
        return localSerial < st[23:0];
    endfunction : decide
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic drain();
        for (int i = 0; i < 60 && expCode.size() > 0; i++) @(negedge clk);
        tick(4);
        `CHK("logsPending", 0, expCode.size())
    endtask : drain
    // Queues one expected event.
    task automatic want(input rafm_event_type c, input logic [4:0] s);
        expCode.push_back(c);
        expSlot.push_back(s);
    endtask : want
    // Queues one expected event and waits for it.
    task automatic ev(input rafm_event_type c, input logic [4:0] s);
        want(c, s);
        drain();
    endtask : ev
    // Sends one partner word, held until the partner end takes it.
    task automatic send(input rafm_msg_type c, input logic [31:0] d);
        int n = 0;
        @(negedge clk);
        txValid = 1'b1;
        txCode = c;
        txData = d;
        do begin
            @(posedge clk);
            n++;
        end while (txReady !== 1'b1 && n < 20);
        @(negedge clk);
        txValid = 1'b0;
    endtask : send
    // Drops and restores the link, then runs one arbitration round.
    task automatic arb(input logic [31:0] st, input logic [31:0] pd);
        lightOn = 1'b0;
        if (linkUp && !gasped) ev(EV_CABLE_BREAK, ANY);
        else tick(4);
        `CHK("roleKept", modelPrimary, isPrimary)
        gasped = 1'b0;
        linkUp = 1'b1;
        want(EV_PARTNER_CONNECTED, ANY);
        lightOn = 1'b1;
        send(MSG_STATUS, st);
        send(MSG_PDTIME, pd);
        tick(10);
        modelPrimary = decide(st, pd);
        `CHK("isPrimary", modelPrimary, isPrimary)
        drain();
    endtask : arb
    // Sets the wall clock by configuration, offset from its present value.
    task automatic cfg_set(input logic [31:0] delta, input logic logged);
        if (logged) want(EV_CLOCK_CHANGE, ANY);
        cfgTime = wallClock + delta;
        cfgTimeValid = 1'b1;
        tick(1);
        cfgTimeValid = 1'b0;
        drain();
    endtask : cfg_set
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // The whole run takes a few hundred cycles; the watchdog allows twenty thousand.
    initial begin
        #1_000_000;
        mismatches++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        tick(3);
        `CHK("resetNumber", 32'h0, logNumber)
        tick(2);
        rst_n = 1'b1;
        rnd = lfsr(rnd);
        localSerial = {1'b0, rnd[22:1], 1'b1};
        for (int s = 0; s < 16; s++) want(EV_MODULE_INSERT, 5'(s));
        moduleVisible = 16'hFFFF;
        drain();
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            sl = (i == 0) ? 5'h00 : (i == 1) ? 5'h0F : {1'b0, rnd[3:0]};
            moduleVisible[sl[3:0]] = 1'b0;
            ev(EV_MODULE_REMOVE, sl);
            moduleVisible[sl[3:0]] = 1'b1;
            ev(EV_MODULE_INSERT, sl);
            netIsolated[sl[3:0]] = 1'b1;
            ev(EV_NET_ISOLATED, sl);
            netIsolated[sl[3:0]] = 1'b0;
            ev(EV_NET_RESTORED, sl);
        end
        faultLine_n = 1'b0;
        ev(EV_FAULT_ACTIVE, 5'h00);
        faultLine_n = 1'b1;
        ev(EV_FAULT_INACTIVE, 5'h00);
        bridgeUnreachable = 1'b1;
        ev(EV_BRIDGE_LOST, ANY);
        bridgeUnreachable = 1'b0;
        drain();
        cfg_set(CLK_STEP_MS, 1'b0);
        cfg_set(CLK_STEP_MS + 32'h1, 1'b1);
        cfg_set(32'h0 - CLK_STEP_MS - 32'h1, 1'b1);
        arb({3'b100, 5'h00, rnd[23:0]}, rnd);
        want(EV_CLOCK_CHANGE, ANY);
        send(MSG_TIME, 32'h0001_0000);
        tick(2);
        `CHK("wallClockSync", 1'b1, (wallClock - 32'h0001_0000) < 32'h4)
        drain();
        arb({3'b001, 5'h00, rnd[23:0]}, rnd);
        localNonRedundant = 1'b1;
        arb({3'b000, 5'h00, rnd[23:0]}, rnd);
        localNonRedundant = 1'b0;
        arb({3'b000, 5'h00, rnd[23:0]}, localPowerDownMs - PD_APART_MS - 32'h1);
        arb({3'b000, 5'h00, localSerial + 24'h1}, localPowerDownMs + PD_APART_MS);
        arb({3'b000, 5'h00, localSerial - 24'h1}, localPowerDownMs - PD_APART_MS);
        swExp++;
        want(EV_PARTNER_SCREAM, ANY);
        send(MSG_LASTGASP, 32'h0);
        tick(2);
        modelPrimary = 1'b1;
        gasped = 1'b1;
        `CHK("gaspPrimary", 1'b1, isPrimary)
        drain();
        arb({3'b000, 5'h00, rnd[23:0]}, rnd);
        powerFail = 1'b1;
        for (int i = 0; i < 20 && !gaspRx; i++) @(negedge clk);
        tick(4);
        `CHK("lastGasp", 1'b1, gaspRx)
        `CHK("deviceLight", 1'b0, deviceLight)
        `CHK("switchovers", swExp, swSeen)
        end_of_test();
    end
endmodule : tb_redundancy_arbiter_fault_monitor
